//--- rtl/ubg_regs.vh
`ifndef UBG_REGS_VH
`define UBG_REGS_VH

// ********
// register offsets (byte addresses)
// ********
`define UBG_ADR_MODE     8'h00
`define UBG_ADR_CTRL     8'h04
`define UBG_ADR_CNT_A    8'h08
`define UBG_ADR_CNT_B    8'h0c
`define UBG_ADR_HIGH_A   8'h10
`define UBG_ADR_LOW_A    8'h14
`define UBG_ADR_HIGH_B   8'h18
`define UBG_ADR_LOW_B    8'h1c
`define UBG_ADR_GAP      8'h20
`define UBG_ADR_STATUS   8'h24

// ********
// field positions and widths
// ********
`define UBG_MODE_W       3
`define UBG_CNT_W        6
`define UBG_TIME_W       11
`define UBG_GAP_W        8
`define UBG_CTRL_TRIG_A  0
`define UBG_CTRL_TRIG_B  1
`define UBG_STAT_BUSY_A  0
`define UBG_STAT_BUSY_B  1
`define UBG_STAT_OUT_A   2
`define UBG_STAT_OUT_B   3

// ********
// configuration codes
// ********
`define UBG_CFG_PP       3'h0
`define UBG_CFG_A_PB     3'h1
`define UBG_CFG_PA_B     3'h2
`define UBG_CFG_A_B      3'h3
`define UBG_CFG_PA_PB    3'h4

// ********
// reset values
// ********
`define UBG_RST_MODE     3'h4
`define UBG_RST_CNT      6'h00
`define UBG_RST_TIME     11'h000
`define UBG_RST_GAP      8'h00

// ********
// timing: 16 MHz count tick from 100 MHz clk
// ********
`define UBG_CLK_MHZ      7'h64
`define UBG_TICK_MHZ     7'h10
`define UBG_ACC_W        7

`endif

//--- rtl/ubg_pulse_gen.v
`timescale 1ns/1ns

`include "ubg_regs.vh"

// ****************************************
// one burst generator: count pulses of high/low
// ****************************************
module ubg_pulse_gen (
    // clock and reset
    input  wire                     clk,
    input  wire                     arst_n,
    // timing tick and trigger
    input  wire                     tick,
    input  wire                     start,
    // burst settings
    input  wire [`UBG_CNT_W-1:0]    count,
    input  wire [`UBG_TIME_W-1:0]   high_time,
    input  wire [`UBG_TIME_W-1:0]   low_time,
    // state seen by the core
    output wire                     pulse,
    output wire                     busy,
    output wire                     in_low,
    output wire [`UBG_TIME_W-1:0]   elapsed
);

    // one-hot states
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_HIGH = 3'b010;
    localparam [2:0] ST_LOW  = 3'b100;

    reg [2:0]             state_q;   // current phase
    reg [`UBG_CNT_W-1:0]  left_q;    // pulses still to emit
    reg [`UBG_TIME_W-1:0] timer_q;   // ticks spent in phase
    reg [`UBG_TIME_W-1:0] hi_q;      // high time latched at start
    reg [`UBG_TIME_W-1:0] lo_q;      // low time latched at start

    wire [`UBG_TIME_W-1:0] timer_nx = timer_q + 11'h001;

    // ****************************************
    // phase sequencer
    // ****************************************
    // times latched at start so a rewrite cannot tear a burst
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_IDLE;
            left_q  <= `UBG_RST_CNT;
            timer_q <= `UBG_RST_TIME;
            hi_q    <= `UBG_RST_TIME;
            lo_q    <= `UBG_RST_TIME;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    // zero count: stays idle, no pulse
                    if (start && count != 6'h00) begin // R8
                        state_q <= ST_HIGH;
                        left_q  <= count; // R8
                        timer_q <= `UBG_RST_TIME;
                        hi_q    <= high_time; // R9
                        lo_q    <= low_time; // R9
                    end
                end
                ST_HIGH: begin
                    if (tick) begin
                        if (timer_nx >= hi_q) begin // R9
                            state_q <= ST_LOW;
                            timer_q <= `UBG_RST_TIME;
                        end else begin
                            timer_q <= timer_nx;
                        end
                    end
                end
                ST_LOW: begin
                    if (tick) begin
                        if (timer_nx >= lo_q) begin // R9
                            timer_q <= `UBG_RST_TIME;
                            left_q  <= left_q - 6'h01;
                            // last pulse done: back to idle
                            if (left_q == 6'h01) begin // R17
                                state_q <= ST_IDLE;
                            end else begin
                                state_q <= ST_HIGH;
                            end
                        end else begin
                            timer_q <= timer_nx;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // outputs straight from state flops
    assign pulse   = state_q[1]; // R17
    assign busy    = ~state_q[0];
    assign in_low  = state_q[2];
    assign elapsed = timer_q;

endmodule // ubg_pulse_gen

//--- rtl/ubg_core.v
// Function
// R1: three-bit field picks one of five configurations
// R2: each output single-ended, push-pull or port-driven
// R3: single-ended uses one output alone
// R4: push-pull alternates both outputs
// R5: port drive passes port level, no timing
// R6: code 000 makes A and B push-pull
// R7: code 000 trigger A starts both outputs
// R8: six-bit pulse count per output
// R9: eleven-bit high/low times in 16 MHz ticks
// R10: push-pull uses A times plus gap time
// R11: code 001 A from generator, B from port
// R12: software times port-driven outputs itself
// R13: code 010 A from port, B from generator
// R14: code 011 both generators run independently
// R15: code 100 both outputs from port bits
// R16: codes 101 to 111 not to be used
// R17: after last pulse output low, generator idle
`timescale 1ns/1ns

`include "ubg_regs.vh"

module ubg_core (
    // clock and reset
    input  wire         clk,
    input  wire         arst_n,
    // register port
    input  wire [7:0]   addr,
    input  wire [15:0]  wdata,
    input  wire         wr_en,
    input  wire         rd_en,
    output reg  [15:0]  rdata,
    // processor port bits, same clock domain
    input  wire         proc_port_bit_a,
    input  wire         proc_port_bit_b,
    // gate drives of the low-side switches
    output reg          gate_out_a,
    output reg          gate_out_b
);

    // ****************************************
    // configuration registers
    // ****************************************
    reg [`UBG_MODE_W-1:0] mode_q;       // burst configuration
    reg [`UBG_CNT_W-1:0]  cnt_a_q;      // pulses per burst, A
    reg [`UBG_CNT_W-1:0]  cnt_b_q;      // pulses per burst, B
    reg [`UBG_TIME_W-1:0] high_time_a;  // A high ticks
    reg [`UBG_TIME_W-1:0] low_time_a;   // A low ticks
    reg [`UBG_TIME_W-1:0] high_time_b;  // B high ticks
    reg [`UBG_TIME_W-1:0] low_time_b;   // B low ticks
    reg [`UBG_GAP_W-1:0]  gap_time;     // push-pull dead ticks

    // ****************************************
    // internal state
    // ****************************************
    reg [`UBG_ACC_W-1:0]  acc_q;        // fractional tick divider
    reg                   tick_q;       // 16 MHz enable pulse
    reg                   trig_a_q;     // trigger A, one cycle
    reg                   trig_b_q;     // trigger B, one cycle
    reg [`UBG_CNT_W-1:0]  pp_left_q;    // push-pull B pulses left
    reg                   pp_on_q;      // push-pull B on last cycle

    // ****************************************
    // decoded configuration
    // ****************************************
    wire cfg_pp   = (mode_q == `UBG_CFG_PP); // R6
    wire cfg_a_pb = (mode_q == `UBG_CFG_A_PB);
    wire cfg_pa_b = (mode_q == `UBG_CFG_PA_B);
    wire cfg_a_b  = (mode_q == `UBG_CFG_A_B);
    wire cfg_pa_pb = (mode_q == `UBG_CFG_PA_PB);

    // generator A runs in codes 000, 001 and 011
    wire use_gen_a = cfg_pp | cfg_a_pb | cfg_a_b; // R1
    // generator B runs only in codes 010 and 011
    wire use_gen_b = cfg_pa_b | cfg_a_b; // R1

    // ****************************************
    // per-generator wiring
    // ****************************************
    wire [1:0]             gen_start;   // start pulse per generator
    wire [1:0]             gen_pulse;   // high phase per generator
    wire [1:0]             gen_busy;    // burst running
    wire [1:0]             gen_low;     // low phase per generator
    wire [`UBG_TIME_W-1:0] gen_el [0:1];  // ticks into phase
    wire [`UBG_CNT_W-1:0]  gen_cnt [0:1]; // pulse count
    wire [`UBG_TIME_W-1:0] gen_hi [0:1];  // high time
    wire [`UBG_TIME_W-1:0] gen_lo [0:1];  // low time

    // a trigger only starts a generator its code uses
    assign gen_start[0] = trig_a_q & use_gen_a; // R7
    assign gen_start[1] = trig_b_q & use_gen_b; // R13
    assign gen_cnt[0]   = cnt_a_q;
    assign gen_cnt[1]   = cnt_b_q;
    assign gen_hi[0]    = high_time_a;
    assign gen_hi[1]    = high_time_b;
    assign gen_lo[0]    = low_time_a;
    assign gen_lo[1]    = low_time_b;

    // ****************************************
    // burst generators A and B
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_gen
            ubg_pulse_gen u_gen (
                .clk       (clk),
                .arst_n    (arst_n),
                .tick      (tick_q),
                .start     (gen_start[gi]),
                .count     (gen_cnt[gi]),
                .high_time (gen_hi[gi]),
                .low_time  (gen_lo[gi]),
                .pulse     (gen_pulse[gi]),
                .busy      (gen_busy[gi]),
                .in_low    (gen_low[gi]),
                .elapsed   (gen_el[gi])
            );
        end
    endgenerate

    // ****************************************
    // 16 MHz tick divider
    // ****************************************
    // adds 16 per clk, wraps at 100: 16 ticks per 100 clks
    wire [`UBG_ACC_W-1:0] acc_sum = acc_q + `UBG_TICK_MHZ;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_q  <= 7'h00;
            tick_q <= 1'b0;
        end else begin
            if (acc_sum >= `UBG_CLK_MHZ) begin // R9
                acc_q  <= acc_sum - `UBG_CLK_MHZ;
                tick_q <= 1'b1;
            end else begin
                acc_q  <= acc_sum;
                tick_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // push-pull second output
    // ****************************************
    // B is on inside A's low phase, a gap after A falls
    // and twice the gap before A rises again; no overlap possible
    wire [`UBG_TIME_W:0] el_gap  = {1'b0, gen_el[0]} + {4'h0, gap_time};
    wire [`UBG_TIME_W:0] lo_wide = {1'b0, low_time_a};

    wire pp_window = cfg_pp & gen_low[0] // R10
                   & (gen_el[0] >= {3'h0, gap_time}) // R10
                   & (el_gap < lo_wide - {4'h0, gap_time}); // R10

    wire pp_on = pp_window & (pp_left_q != 6'h00); // R8

    // counts B pulses of the push-pull pair
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pp_left_q <= `UBG_RST_CNT;
            pp_on_q   <= 1'b0;
        end else begin
            pp_on_q <= pp_on;
            if (gen_start[0] && cfg_pp && !gen_busy[0]) begin
                // trigger A loads B's own count too
                pp_left_q <= cnt_b_q; // R7
            end else if (!cfg_pp || !gen_busy[0]) begin
                // burst over: B stops with A
                pp_left_q <= `UBG_RST_CNT; // R17
            end else if (pp_on_q && !pp_on) begin
                // falling edge of a B pulse
                pp_left_q <= pp_left_q - 6'h01; // R8
            end
        end
    end

    // ****************************************
    // output steering per configuration
    // ****************************************
    reg out_a_d;   // next gate A level
    reg out_b_d;   // next gate B level

    always @* begin
        out_a_d = 1'b0;
        out_b_d = 1'b0;
        case (mode_q)
            `UBG_CFG_PP: begin
                // push-pull pair from generator A timing
                out_a_d = gen_pulse[0]; // R4
                out_b_d = pp_on; // R4
            end
            `UBG_CFG_A_PB: begin
                // A single-ended, B from port
                out_a_d = gen_pulse[0]; // R11
                out_b_d = proc_port_bit_b; // R11
            end
            `UBG_CFG_PA_B: begin
                // A from port, B single-ended
                out_a_d = proc_port_bit_a; // R13
                out_b_d = gen_pulse[1]; // R13
            end
            `UBG_CFG_A_B: begin
                // two independent single-ended outputs
                out_a_d = gen_pulse[0]; // R14
                out_b_d = gen_pulse[1]; // R14
            end
            `UBG_CFG_PA_PB: begin
                // both follow port bits, no timing
                out_a_d = proc_port_bit_a; // R15
                out_b_d = proc_port_bit_b; // R15
            end
            default: begin
                // reserved codes keep both switches off
                out_a_d = 1'b0;
                out_b_d = 1'b0;
            end
        endcase
    end

    // gate drives from flops; single-ended: one gen per pin
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gate_out_a <= 1'b0;
            gate_out_b <= 1'b0;
        end else begin
            gate_out_a <= out_a_d; // R2 R3
            gate_out_b <= out_b_d; // R2 R5
        end
    end

    // ****************************************
    // register writes
    // ****************************************
    wire wr_ctrl = wr_en & (addr == `UBG_ADR_CTRL);

    // triggers are one-cycle pulses from write-one
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            trig_a_q <= 1'b0;
            trig_b_q <= 1'b0;
        end else begin
            trig_a_q <= wr_ctrl & wdata[`UBG_CTRL_TRIG_A]; // R7
            trig_b_q <= wr_ctrl & wdata[`UBG_CTRL_TRIG_B]; // R13
        end
    end

    // configuration storage
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_q      <= `UBG_RST_MODE;
            cnt_a_q     <= `UBG_RST_CNT;
            cnt_b_q     <= `UBG_RST_CNT;
            high_time_a <= `UBG_RST_TIME;
            low_time_a  <= `UBG_RST_TIME;
            high_time_b <= `UBG_RST_TIME;
            low_time_b  <= `UBG_RST_TIME;
            gap_time    <= `UBG_RST_GAP;
        end else if (wr_en) begin
            case (addr)
                `UBG_ADR_MODE: begin
                    mode_q <= wdata[`UBG_MODE_W-1:0]; // R1
                end
                `UBG_ADR_CNT_A: begin
                    cnt_a_q <= wdata[`UBG_CNT_W-1:0]; // R8
                end
                `UBG_ADR_CNT_B: begin
                    cnt_b_q <= wdata[`UBG_CNT_W-1:0]; // R8
                end
                `UBG_ADR_HIGH_A: begin
                    high_time_a <= wdata[`UBG_TIME_W-1:0]; // R9
                end
                `UBG_ADR_LOW_A: begin
                    low_time_a <= wdata[`UBG_TIME_W-1:0]; // R9
                end
                `UBG_ADR_HIGH_B: begin
                    high_time_b <= wdata[`UBG_TIME_W-1:0]; // R9
                end
                `UBG_ADR_LOW_B: begin
                    low_time_b <= wdata[`UBG_TIME_W-1:0]; // R9
                end
                `UBG_ADR_GAP: begin
                    gap_time <= wdata[`UBG_GAP_W-1:0]; // R10
                end
                default: begin
                    // control and status hold no stored bits
                    mode_q <= mode_q;
                end
            endcase
        end
    end

    // ****************************************
    // register reads
    // ****************************************
    reg [15:0] rd_d;   // read value for the addressed word

    always @* begin
        rd_d = 16'h0000;
        case (addr)
            `UBG_ADR_MODE:   rd_d = {13'h0000, mode_q};
            `UBG_ADR_CTRL:   rd_d = {14'h0000, gen_busy};
            `UBG_ADR_CNT_A:  rd_d = {10'h000, cnt_a_q};
            `UBG_ADR_CNT_B:  rd_d = {10'h000, cnt_b_q};
            `UBG_ADR_HIGH_A: rd_d = {5'h00, high_time_a};
            `UBG_ADR_LOW_A:  rd_d = {5'h00, low_time_a};
            `UBG_ADR_HIGH_B: rd_d = {5'h00, high_time_b};
            `UBG_ADR_LOW_B:  rd_d = {5'h00, low_time_b};
            `UBG_ADR_GAP:    rd_d = {8'h00, gap_time};
            `UBG_ADR_STATUS: rd_d = {12'h000, gate_out_b, gate_out_a, gen_busy};
            default:         rd_d = 16'h0000;
        endcase
    end

    // data stand only in the cycle after the read strobe
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= 16'h0000;
        end else if (rd_en) begin
            rdata <= rd_d;
        end else begin
            rdata <= 16'h0000;
        end
    end

endmodule // ubg_core

//--- test/ubg_core_monitor.sv
`timescale 1ns/1ns

`include "ubg_regs.vh"

module ubg_core_monitor (
    // clock and reset
    input wire        clk,
    input wire        arst_n,
    // register port
    input wire [7:0]  addr,
    input wire [15:0] wdata,
    input wire        wr_en,
    input wire        rd_en,
    input wire [15:0] rdata,
    // port bits and gate drives
    input wire        proc_port_bit_a,
    input wire        proc_port_bit_b,
    input wire        gate_out_a,
    input wire        gate_out_b
);
    // ********
    // shadow copies of the settings
    // ********
    reg  [2:0] mode_q;  // live configuration
    reg  [5:0] cnt_a_q; // pulse count a
    reg  [5:0] cnt_b_q; // pulse count b
    reg  [7:0] gap_q;   // dead time
    wire       trig_a = wr_en && addr == `UBG_ADR_CTRL && wdata[0];
    wire       trig_b = wr_en && addr == `UBG_ADR_CTRL && wdata[1];
    wire       a_gen  = mode_q < 3'h4 && mode_q != 3'h2;
    wire       b_gen  = mode_q == 3'h2 || mode_q == 3'h3;

    // follow register writes the way the block takes them
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_q  <= `UBG_RST_MODE;
            cnt_a_q <= 6'h00;
            cnt_b_q <= 6'h00;
            gap_q   <= 8'h00;
        end else if (wr_en) begin
            if (addr == `UBG_ADR_MODE) mode_q <= wdata[2:0];
            if (addr == `UBG_ADR_CNT_A) cnt_a_q <= wdata[5:0];
            if (addr == `UBG_ADR_CNT_B) cnt_b_q <= wdata[5:0];
            if (addr == `UBG_ADR_GAP) gap_q <= wdata[7:0];
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    // ********
    // checks
    // ********
    port_a_follow_a: assert property ((mode_q == 3'h2 || mode_q == 3'h4) && $stable(mode_q)
        |-> gate_out_a == $past(proc_port_bit_a)) else $error("gate a off its port bit");
    port_b_follow_a: assert property ((mode_q == 3'h1 || mode_q == 3'h4) && $stable(mode_q)
        |-> gate_out_b == $past(proc_port_bit_b)) else $error("gate b off its port bit");
    reserved_off_a: assert property (mode_q > 3'h4 && $past(mode_q) > 3'h4
        |-> !gate_out_a && !gate_out_b) else $error("gate driven in reserved mode");
    pp_no_overlap_a: assert property (mode_q == 3'h0 && $stable(mode_q)
        |-> !(gate_out_a && gate_out_b)) else $error("both gates on in push-pull");
    gap_after_a_a: assert property (mode_q == 3'h0 && gap_q != 8'h00 && $fell(gate_out_a)
        |-> !gate_out_b [*4]) else $error("gate b on inside gap");
    gap_after_b_a: assert property (mode_q == 3'h0 && gap_q != 8'h00 && $fell(gate_out_b)
        |-> !gate_out_a [*4]) else $error("gate a on inside gap");
    trig_start_a: assert property (trig_a && a_gen && cnt_a_q != 6'h00 && !gate_out_a
        |-> ##2 !gate_out_a ##1 gate_out_a) else $error("burst a start late");
    trig_start_b_a: assert property (trig_b && b_gen && cnt_b_q != 6'h00 && !gate_out_b
        |-> ##2 !gate_out_b ##1 gate_out_b) else $error("burst b start late");
    zero_count_a: assert property (trig_a && mode_q == 3'h3 && cnt_a_q == 6'h00
        |-> !gate_out_a [*8]) else $error("pulse with zero count");
    high_min_a: assert property (mode_q == 3'h3 && $rose(gate_out_a)
        |-> gate_out_a [*5]) else $error("high phase too short");

    // main scenarios reached
    pp_seen_c: cover property (mode_q == 3'h0 && gate_out_b);
    gen_seen_c: cover property (mode_q == 3'h3 && $rose(gate_out_a));
    trig_b_seen_c: cover property (trig_b && b_gen && cnt_b_q != 6'h00);
endmodule // ubg_core_monitor

bind ubg_core ubg_core_monitor mon (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .proc_port_bit_a(proc_port_bit_a), .proc_port_bit_b(proc_port_bit_b),
    .gate_out_a(gate_out_a), .gate_out_b(gate_out_b));

//--- test/ubg_fet_model.sv
`timescale 1ns/1ns

// ********
// low-side switch pair: counts switching
// ********
module ubg_fet_model (
    // clock and reset
    input  wire        clk,
    input  wire        arst_n,
    // gate drives
    input  wire        gate_a,
    input  wire        gate_b,
    // counter clear
    input  wire        clr,
    // switching activity
    output reg  [15:0] pulses_a,
    output reg  [15:0] pulses_b,
    output reg         shoot_q
);
    reg a_q; // last gate a
    reg b_q; // last gate b

    // count turn-on edges, flag both coils on at once
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            a_q      <= 1'b0;
            b_q      <= 1'b0;
            pulses_a <= 16'h0000;
            pulses_b <= 16'h0000;
            shoot_q  <= 1'b0;
        end else begin
            a_q <= gate_a;
            b_q <= gate_b;
            if (clr) begin
                pulses_a <= 16'h0000;
                pulses_b <= 16'h0000;
                shoot_q  <= 1'b0;
            end else begin
                pulses_a <= pulses_a + {15'h0000, gate_a & ~a_q};
                pulses_b <= pulses_b + {15'h0000, gate_b & ~b_q};
                shoot_q  <= shoot_q | (gate_a & gate_b);
            end
        end
    end
endmodule // ubg_fet_model

//--- test/ubg_core_tb.sv
`timescale 1ns/1ns

`include "ubg_regs.vh"

module ubg_core_tb;
    reg         clk, arst_n, wr_en, rd_en, clr, proc_port_bit_a, proc_port_bit_b;
    reg  [7:0]  addr;
    reg  [15:0] wdata, d;
    wire [15:0] rdata, pulses_a, pulses_b;
    wire        gate_out_a, gate_out_b, shoot;
    integer     mismatches, num_checks, i;
    reg  [5:0]  cnts [0:2];

    ubg_core dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata(rdata), .proc_port_bit_a(proc_port_bit_a), .proc_port_bit_b(proc_port_bit_b),
        .gate_out_a(gate_out_a), .gate_out_b(gate_out_b));
    ubg_fet_model fets (.clk(clk), .arst_n(arst_n), .gate_a(gate_out_a), .gate_b(gate_out_b), .clr(clr),
        .pulses_a(pulses_a), .pulses_b(pulses_b), .shoot_q(shoot));

    // ********
    // bus tasks and compare
    // ********
    task wr(input [7:0] a, input [15:0] v);
        begin
            @(posedge clk);
            addr  <= a;
            wdata <= v;
            wr_en <= 1'b1;
            @(posedge clk);
            wr_en <= 1'b0;
        end
    endtask

    // data stands only in the cycle after the strobe
    task rd(input [7:0] a, output [15:0] v);
        begin
            @(posedge clk);
            addr  <= a;
            rd_en <= 1'b1;
            @(posedge clk);
            rd_en <= 1'b0;
            @(posedge clk);
            v = rdata;
        end
    endtask

    task chk_word(input [15:0] got, input [15:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    task test_done;
        begin
            $display("checks=%0d mismatches=%0d", num_checks, mismatches);
            if (mismatches == 0 && num_checks > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask

    // poll status until both idle, bounded
    task wait_idle;
        reg [15:0] s;
        integer    n;
        begin
            s = 16'h0003;
            repeat (4) @(posedge clk);
            for (n = 0; n < 3000 && s[1:0] !== 2'b00; n = n + 1)
                rd(`UBG_ADR_STATUS, s);
            if (s[1:0] !== 2'b00) begin
                mismatches = mismatches + 1;
                test_done;
            end
        end
    endtask

    // set mode, clear counters, fire, count pulses
    task burst(input [2:0] m, input [15:0] ctrl, input [15:0] ea, input [15:0] eb);
        begin
            wr(`UBG_ADR_MODE, {13'h0000, m});
            repeat (3) @(posedge clk);
            clr <= 1'b1;
            @(posedge clk);
            clr <= 1'b0;
            wr(`UBG_ADR_CTRL, ctrl);
            wait_idle;
            chk_word(pulses_a, ea);
            chk_word(pulses_b, eb);
        end
    endtask

    // ********
    // clock, watchdog
    // ********
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        repeat (100000) @(posedge clk);
        mismatches = mismatches + 1;
        test_done;
    end

    // ********
    // main sequence
    // ********
    initial begin
        mismatches = 0;
        num_checks = 0;
        {arst_n, wr_en, rd_en, clr, proc_port_bit_a, proc_port_bit_b} = 6'h00;
        addr = 8'h00;
        wdata = 16'h0000;
        cnts[0] = 6'h00;
        cnts[1] = 6'h01;
        cnts[2] = 6'h3f;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        // reset values and field widths
        rd(`UBG_ADR_MODE, d);
        chk_word(d, 16'h0004);
        rd(`UBG_ADR_CNT_A, d);
        chk_word(d, 16'h0000);
        wr(`UBG_ADR_HIGH_A, 16'hffff);
        rd(`UBG_ADR_HIGH_A, d);
        chk_word(d, 16'h07ff);
        wr(`UBG_ADR_GAP, 16'hffff);
        rd(`UBG_ADR_GAP, d);
        chk_word(d, 16'h00ff);
        wr(`UBG_ADR_CNT_A, 16'hffff);
        rd(`UBG_ADR_CNT_A, d);
        chk_word(d, 16'h003f);
        rd(8'h28, d);
        chk_word(d, 16'h0000);
        // port drive after reset: every level pair
        for (i = 0; i < 4; i = i + 1) begin
            @(posedge clk);
            {proc_port_bit_a, proc_port_bit_b} <= i[1:0];
            repeat (3) @(posedge clk);
            chk_word({14'h0000, gate_out_a, gate_out_b}, {14'h0000, i[1:0]});
        end
        {proc_port_bit_a, proc_port_bit_b} <= 2'b00;
        // independent generators, count 0, 1 and 63
        wr(`UBG_ADR_HIGH_A, 16'h0002);
        wr(`UBG_ADR_LOW_A, 16'h0003);
        wr(`UBG_ADR_HIGH_B, 16'h0003);
        wr(`UBG_ADR_LOW_B, 16'h0002);
        wr(`UBG_ADR_CNT_B, 16'h0005);
        for (i = 0; i < 3; i = i + 1) begin
            wr(`UBG_ADR_CNT_A, {10'h000, cnts[i]});
            burst(3'h3, 16'h0003, {10'h000, cnts[i]}, 16'h0005);
            chk_word({14'h0000, gate_out_a, gate_out_b}, 16'h0000);
        end
        // generator a with port b, b trigger ignored
        wr(`UBG_ADR_CNT_A, 16'h0002);
        proc_port_bit_b <= 1'b1;
        burst(3'h1, 16'h0003, 16'h0002, 16'h0000);
        chk_word({15'h0000, gate_out_b}, 16'h0001);
        rd(`UBG_ADR_STATUS, d);
        chk_word(d, 16'h0008);
        proc_port_bit_b <= 1'b0;
        // port a with generator b, a trigger ignored
        wr(`UBG_ADR_CNT_B, 16'h0004);
        burst(3'h2, 16'h0003, 16'h0000, 16'h0004);
        // push-pull on trigger a, b capped by a
        wr(`UBG_ADR_HIGH_A, 16'h0003);
        wr(`UBG_ADR_LOW_A, 16'h0008);
        wr(`UBG_ADR_GAP, 16'h0001);
        wr(`UBG_ADR_CNT_A, 16'h0004);
        wr(`UBG_ADR_CNT_B, 16'h0006);
        burst(3'h0, 16'h0001, 16'h0004, 16'h0004);
        chk_word({15'h0000, shoot}, 16'h0000);
        wr(`UBG_ADR_CNT_B, 16'h0002);
        burst(3'h0, 16'h0001, 16'h0004, 16'h0002);
        chk_word({15'h0000, shoot}, 16'h0000);
        // reserved codes keep both gates off
        proc_port_bit_a <= 1'b1;
        proc_port_bit_b <= 1'b1;
        for (i = 5; i < 8; i = i + 1) begin
            burst(i[2:0], 16'h0003, 16'h0000, 16'h0000);
            chk_word({14'h0000, gate_out_a, gate_out_b}, 16'h0000);
        end
        test_done;
    end
endmodule // ubg_core_tb
